/* logic/tws_counter.sv */
// Purpose: Constants for the timer set and one programmable down counter
// Assumes: One processor clock; slower rates arrive as one-cycle enables
// Notes: The counter is instantiated twice per dual-timer unit

// ==============================
// Shared constants
package tws_pkg;
   localparam int unsigned TWS_UNITS = 8;
   localparam int unsigned TWS_CNTS = 2 * TWS_UNITS;
   localparam int unsigned TWS_SLOW_UNITS = 4;
   localparam int unsigned TWS_CW = 32;
   localparam int unsigned TWS_NW = 16;
   localparam int unsigned TWS_TW = 24;
   localparam logic [1:0] TWS_MODE_FREE = 2'h0;
   localparam logic [1:0] TWS_MODE_PERIODIC = 2'h1;
   localparam logic [1:0] TWS_MODE_ONESHOT = 2'h2;
   localparam logic [1:0] TWS_DIV_1 = 2'h0;
   localparam logic [1:0] TWS_DIV_16 = 2'h1;
   localparam logic [1:0] TWS_DIV_256 = 2'h2;
   localparam logic [7:0] TWS_PRE_LAST_16 = 8'h0F;
   localparam logic [7:0] TWS_PRE_LAST_256 = 8'hFF;
   localparam logic [31:0] TWS_MAX_32 = 32'hFFFFFFFF;
   localparam logic [31:0] TWS_MAX_16 = 32'h0000FFFF;
   localparam logic [31:0] TWS_ONE = 32'h00000001;
   localparam logic [23:0] TWS_TICK_CLEAR = 24'h000000;
endpackage

`timescale 1ns/100ps

// ==============================
// One prescaled down counter
module tws_counter (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic tick_in,
   input wire logic enable_in,
   input wire logic wide_in,
   input wire logic [1:0] mode_in,
   input wire logic [1:0] prescale_in,
   input wire logic load_in,
   input wire logic [31:0] load_value_in,
   output logic [31:0] value_out,
   output logic irq_out
);
   import tws_pkg::*;

   logic [7:0] pre_ff;
   logic [31:0] reload_ff;
   logic halted_ff;
   logic ptick;
   logic [31:0] max_val;
   logic [31:0] masked_load;

   // Width masking and prescaled tick
   assign max_val = wide_in ? TWS_MAX_32 : TWS_MAX_16;
   assign masked_load = load_value_in & max_val;
   always_comb begin
      unique case (prescale_in)
         TWS_DIV_16: ptick = tick_in && (pre_ff[3:0] == TWS_PRE_LAST_16[3:0]);
         TWS_DIV_256: ptick = tick_in && (pre_ff == TWS_PRE_LAST_256);
         default: ptick = tick_in;
      endcase
   end

   // Prescaler, restarted by a load
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pre_ff <= 8'h00;
      end else if (load_in || !enable_in) begin
         pre_ff <= 8'h00;
      end else if (tick_in) begin
         pre_ff <= pre_ff + 8'h01;
      end
   end

   // Programmed reload value
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reload_ff <= 32'h00000000;
      end else if (load_in) begin
         reload_ff <= masked_load;
      end
   end

   // Count, wrap, reload and halt
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         value_out <= 32'h00000000;
         halted_ff <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         irq_out <= 1'b0;
         if (load_in) begin
            value_out <= masked_load;
            halted_ff <= 1'b0;
         end else if (enable_in && ptick && !halted_ff) begin
            if (value_out == 32'h00000000) begin
               unique case (mode_in)
                  TWS_MODE_PERIODIC: value_out <= reload_ff;
                  TWS_MODE_ONESHOT: halted_ff <= 1'b1;
                  default: value_out <= max_val;
               endcase
            end else begin
               value_out <= (value_out - TWS_ONE) & max_val;
               irq_out <= (value_out == TWS_ONE);
               halted_ff <= (value_out == TWS_ONE) && (mode_in == TWS_MODE_ONESHOT);
            end
         end
      end
   end

   sequence seq_load;
      load_in;
   endsequence

   property prop_load_then_count;
      @(posedge sys_clk_in) disable iff (!rst_n_in)
         seq_load ##1 (enable_in && ptick && !load_in && value_out != 32'h00000000)
         |=> value_out == (($past(value_out) - TWS_ONE) & max_val);
   endproperty

   chk_load_then_count: assert property (prop_load_then_count)
      else $error("counter did not resume after load");
   chk_load_takes: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      seq_load |=> value_out == $past(masked_load))
      else $error("load value not taken");
   chk_irq_at_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      irq_out |-> value_out == 32'h00000000 && $past(value_out) == TWS_ONE)
      else $error("interrupt without reaching zero");
   chk_free_wrap: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (enable_in && ptick && !halted_ff && !load_in && value_out == 32'h00000000
      && mode_in == TWS_MODE_FREE) |=> value_out == $past(max_val))
      else $error("free mode did not wrap to maximum");
   chk_periodic_reload: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (enable_in && ptick && !halted_ff && !load_in && value_out == 32'h00000000
      && mode_in == TWS_MODE_PERIODIC) |=> value_out == $past(reload_ff))
      else $error("periodic mode did not reload");
   chk_oneshot_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (halted_ff && !load_in) |=> $stable(value_out) && halted_ff)
      else $error("one-shot counter moved while halted");
   chk_narrow_width: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (!wide_in && $stable(wide_in)) |=> value_out[31:16] == 16'h0000 || wide_in)
      else $error("narrow counter exceeds 16 bits");
   chk_prescale_div: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (prescale_in == TWS_DIV_256 && ptick) |-> tick_in && pre_ff == 8'hFF)
      else $error("prescaler divide by 256 wrong");
endmodule

/* logic/tws_top.sv */
// Purpose: Timer set with dual-timer units, supervision timer, core tick timer
// Assumes: sys_clk_in is the processor clock; slow and external clocks are pins
// Notes: Control and status are plain ports; counter fields are packed per index

`timescale 1ns/100ps

// ==============================
// Top of the timer set
module tws_top (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic slow_rc_oscillator_in,
   input wire logic external_clock_input_in,
   input wire logic [tws_pkg::TWS_CNTS-1:0] dt_enable_in,
   input wire logic [tws_pkg::TWS_CNTS-1:0] dt_wide_in,
   input wire logic [2*tws_pkg::TWS_CNTS-1:0] dt_mode_in,
   input wire logic [2*tws_pkg::TWS_CNTS-1:0] dt_prescale_in,
   input wire logic [tws_pkg::TWS_CNTS-1:0] dt_load_in,
   input wire logic [32*tws_pkg::TWS_CNTS-1:0] dt_load_value_in,
   output logic [32*tws_pkg::TWS_CNTS-1:0] dt_value_out,
   output logic [tws_pkg::TWS_CNTS-1:0] dt_irq_out,
   input wire logic sv_enable_in,
   input wire logic sv_clk_sel_in,
   input wire logic sv_irq_en_in,
   input wire logic sv_rst_en_in,
   input wire logic sv_load_in,
   input wire logic [31:0] sv_load_value_in,
   output logic [31:0] sv_value_out,
   output logic sv_irq_out,
   output logic sv_reset_out,
   input wire logic ct_write_in,
   output logic [23:0] ct_value_out
);
   import tws_pkg::*;

   logic [2:0] slow_sync_ff;
   logic [2:0] ext_sync_ff;
   logic slow_lvl_ff;
   logic ext_lvl_ff;
   logic slow_tick;
   logic ext_tick;
   logic sv_tick;
   logic [31:0] sv_reload_ff;

   // ==============================
   // Pin synchronisers and edge pulses
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         slow_sync_ff <= 3'h0;
         ext_sync_ff <= 3'h0;
      end else begin
         slow_sync_ff <= {slow_sync_ff[1:0], slow_rc_oscillator_in};
         ext_sync_ff <= {ext_sync_ff[1:0], external_clock_input_in};
      end
   end

   // Level accepted once stages two and three agree
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         slow_lvl_ff <= 1'b0;
         ext_lvl_ff <= 1'b0;
      end else begin
         if (slow_sync_ff[1] == slow_sync_ff[2]) begin
            slow_lvl_ff <= slow_sync_ff[2];
         end
         if (ext_sync_ff[1] == ext_sync_ff[2]) begin
            ext_lvl_ff <= ext_sync_ff[2];
         end
      end
   end

   assign slow_tick = slow_sync_ff[1] && slow_sync_ff[2] && !slow_lvl_ff;
   assign ext_tick = ext_sync_ff[1] && ext_sync_ff[2] && !ext_lvl_ff;

   // ==============================
   // Dual-timer units, two counters each sharing one tick
   for (genvar u = 0; u < TWS_UNITS; u++) begin : g_unit
      logic unit_tick;
      assign unit_tick = (u < TWS_SLOW_UNITS) ? slow_tick : 1'b1;
      for (genvar c = 0; c < 2; c++) begin : g_cnt
         localparam int unsigned K = 2 * u + c;
         tws_counter u_cnt (
            .sys_clk_in(sys_clk_in),
            .rst_n_in(rst_n_in),
            .tick_in(unit_tick),
            .enable_in(dt_enable_in[K]),
            .wide_in(dt_wide_in[K]),
            .mode_in(dt_mode_in[2*K +: 2]),
            .prescale_in(dt_prescale_in[2*K +: 2]),
            .load_in(dt_load_in[K]),
            .load_value_in(dt_load_value_in[32*K +: 32]),
            .value_out(dt_value_out[32*K +: 32]),
            .irq_out(dt_irq_out[K])
         );
      end
   end

   // ==============================
   // Supervision timer
   assign sv_tick = sv_clk_sel_in ? ext_tick : slow_tick;

   // Reload value kept for restart after expiry
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sv_reload_ff <= 32'h00000000;
      end else if (sv_load_in) begin
         sv_reload_ff <= sv_load_value_in;
      end
   end

   // Count down, fire on the tick at one, restart from reload
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sv_value_out <= 32'h00000000;
         sv_irq_out <= 1'b0;
         sv_reset_out <= 1'b0;
      end else begin
         sv_reset_out <= 1'b0;
         if (sv_load_in) begin
            sv_value_out <= sv_load_value_in;
            sv_irq_out <= 1'b0;
         end else if (sv_enable_in && sv_tick && sv_value_out != 32'h00000000) begin
            if (sv_value_out == TWS_ONE) begin
               sv_value_out <= sv_reload_ff;
               sv_irq_out <= sv_irq_en_in || sv_irq_out;
               sv_reset_out <= sv_rst_en_in;
            end else begin
               sv_value_out <= sv_value_out - TWS_ONE;
            end
         end
      end
   end

   // ==============================
   // Core tick timer, every processor clock
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ct_value_out <= TWS_TICK_CLEAR;
      end else if (ct_write_in) begin
         ct_value_out <= TWS_TICK_CLEAR;
      end else begin
         ct_value_out <= ct_value_out - 24'h000001;
      end
   end

   chk_tick_decrement: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !ct_write_in |=> ct_value_out == $past(ct_value_out) - 24'h000001)
      else $error("core tick did not decrement");
   chk_tick_clear_wrap: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ct_write_in ##1 !ct_write_in |=> ct_value_out == 24'hFFFFFF)
      else $error("core tick did not clear then wrap");
   chk_sv_fire: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (sv_enable_in && sv_tick && !sv_load_in && sv_value_out == TWS_ONE)
      |=> sv_reset_out == $past(sv_rst_en_in) && (sv_irq_out || !$past(sv_irq_en_in)))
      else $error("supervision expiry action wrong");
   chk_sv_pulse: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      sv_reset_out |=> !sv_reset_out)
      else $error("supervision reset longer than one cycle");
   chk_fast_units: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (dt_enable_in[15] && !dt_load_in[15] && dt_prescale_in[31:30] == TWS_DIV_1
      && dt_value_out[511:480] > 32'h00000001) |=> dt_value_out[511:480]
      == $past(dt_value_out[511:480]) - 32'h00000001)
      else $error("processor-clock unit did not count each cycle");
endmodule

/* verif/timer_watchdog_tick_set_tb.sv */
// Purpose: Self-checking bench for the timer set top
// Assumes: Assertions live in the design files; bench drives all pins itself
// Notes: Slow and external clock pins are toggled far faster than real rates

`timescale 1ns/100ps

// ==============================
// Bench top
module timer_watchdog_tick_set_tb;
   import tws_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic slow = 1'b0;
   logic ext = 1'b0;
   logic [TWS_CNTS-1:0] en = '1, wide = '1, ld = '0;
   logic [2*TWS_CNTS-1:0] mode = '0, pre = '0;
   logic [32*TWS_CNTS-1:0] ldv = '0, dv;
   logic [TWS_CNTS-1:0] irq;
   logic sv_sel = 1'b0, sv_ld = 1'b0, sv_irq, sv_rst;
   logic [31:0] sv_ldv = 32'h0, sv_val;
   logic ct_wr = 1'b0;
   logic [23:0] ct_val;
   int fail_count = 0, num_checks = 0, rst_seen;

   tws_top dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .slow_rc_oscillator_in(slow),
      .external_clock_input_in(ext), .dt_enable_in(en), .dt_wide_in(wide), .dt_mode_in(mode),
      .dt_prescale_in(pre), .dt_load_in(ld), .dt_load_value_in(ldv), .dt_value_out(dv),
      .dt_irq_out(irq), .sv_enable_in(1'b1), .sv_clk_sel_in(sv_sel), .sv_irq_en_in(1'b1),
      .sv_rst_en_in(1'b1), .sv_load_in(sv_ld), .sv_load_value_in(sv_ldv),
      .sv_value_out(sv_val), .sv_irq_out(sv_irq), .sv_reset_out(sv_rst),
      .ct_write_in(ct_wr), .ct_value_out(ct_val));

   // Processor clock, 8 ns period
   always #4 sys_clk_in = ~sys_clk_in;

   // ==============================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   function automatic logic [31:0] val(input int k);
      return dv[32*k +: 32];
   endfunction

   task automatic load(input int k, input logic [1:0] md, input logic [1:0] pr,
                       input logic w, input logic [31:0] v);
      mode[2*k +: 2] = md;
      pre[2*k +: 2] = pr;
      wide[k] = w;
      ldv[32*k +: 32] = v;
      ld[k] = 1'b1;
      cyc(1);
      ld[k] = 1'b0;
   endtask

   task automatic wait_val(input int k, input logic [31:0] v);
      for (int i = 0; i < 40 && val(k) !== v; i++) cyc(1);
      chk("loaded value", val(k), v);
   endtask

   // One rising edge on the slow or external pin, counting reset pulses
   task automatic pin_pulse(input bit on_ext);
      if (on_ext) ext = 1'b1; else slow = 1'b1;
      for (int i = 0; i < 10; i++) begin
         cyc(1);
         rst_seen += sv_rst;
      end
      ext = 1'b0;
      slow = 1'b0;
      for (int i = 0; i < 10; i++) begin
         cyc(1);
         rst_seen += sv_rst;
      end
   endtask

   // ==============================
   // Scenarios
   task automatic test_core_tick;
      logic [23:0] v;
      chk("tick after reset", ct_val, 24'hFFFFFF);
      v = ct_val;
      cyc(1);
      chk("tick step", ct_val, v - 24'h1);
      ct_wr = 1'b1;
      cyc(1);
      ct_wr = 1'b0;
      chk("tick cleared", ct_val, TWS_TICK_CLEAR);
      cyc(1);
      chk("tick wrap", ct_val, 24'hFFFFFF);
      $display("core tick test done");
   endtask

   task automatic test_periodic;
      load(8, TWS_MODE_PERIODIC, TWS_DIV_1, 1'b1, 32'h2);
      wait_val(8, 32'h2);
      cyc(1);
      chk("count", val(8), 32'h1);
      chk("irq early", irq[8], 1'b0);
      cyc(1);
      chk("count zero", val(8), 32'h0);
      chk("irq at zero", irq[8], 1'b1);
      cyc(1);
      chk("reload", val(8), 32'h2);
      chk("irq pulse", irq[8], 1'b0);
      $display("periodic test done");
   endtask

   task automatic test_free;
      load(9, TWS_MODE_FREE, TWS_DIV_1, 1'b0, 32'h12340001);
      load(10, TWS_MODE_FREE, TWS_DIV_1, 1'b1, 32'h1);
      wait_val(9, 32'h0000FFFF);
      chk("wide at zero", val(10), 32'h0);
      cyc(1);
      chk("narrow step", val(9), 32'h0000FFFE);
      chk("wide wrap", val(10), TWS_MAX_32);
      $display("free test done");
   endtask

   task automatic test_oneshot;
      load(11, TWS_MODE_ONESHOT, TWS_DIV_1, 1'b1, 32'h1);
      wait_val(11, 32'h0);
      cyc(6);
      chk("halted", val(11), 32'h0);
      chk("no irq halted", irq[11], 1'b0);
      load(11, TWS_MODE_ONESHOT, TWS_DIV_1, 1'b1, 32'h3);
      wait_val(11, 32'h3);
      cyc(1);
      chk("resumed", val(11), 32'h2);
      $display("one-shot test done");
   endtask

   task automatic test_prescale(input int k, input logic [1:0] pr, input int n);
      int i;
      load(k, TWS_MODE_PERIODIC, pr, 1'b1, 32'h5);
      wait_val(k, 32'h5);
      for (i = 0; i < 300 && val(k) === 32'h5; i++) cyc(1);
      for (i = 0; i < 300 && val(k) === 32'h4; i++) cyc(1);
      chk("prescale span", i, n);
      $display("prescale test done");
   endtask

   task automatic test_slow_unit;
      load(0, TWS_MODE_FREE, TWS_DIV_1, 1'b1, 32'hA);
      wait_val(0, 32'hA);
      cyc(20);
      chk("slow idle", val(0), 32'hA);
      repeat (3) pin_pulse(1'b0);
      chk("slow count", val(0), 32'h7);
      $display("slow unit test done");
   endtask

   task automatic test_supervision;
      rst_seen = 0;
      sv_sel = 1'b1;
      sv_ldv = 32'h2;
      sv_ld = 1'b1;
      cyc(1);
      sv_ld = 1'b0;
      cyc(2);
      chk("sv loaded", sv_val, 32'h2);
      pin_pulse(1'b0);
      chk("sv ignores slow", sv_val, 32'h2);
      pin_pulse(1'b1);
      chk("sv ext step", sv_val, 32'h1);
      pin_pulse(1'b1);
      chk("sv reload", sv_val, 32'h2);
      chk("sv irq", sv_irq, 1'b1);
      chk("sv resets", rst_seen, 1);
      sv_sel = 1'b0;
      sv_ld = 1'b1;
      cyc(1);
      sv_ld = 1'b0;
      cyc(2);
      chk("sv irq cleared", sv_irq, 1'b0);
      pin_pulse(1'b0);
      chk("sv slow step", sv_val, 32'h1);
      $display("supervision test done");
   endtask

   // ==============================
   // Verdict and run control
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Main sequence after eight reset cycles
   initial begin
      cyc(8);
      rst_n_in = 1'b1;
      cyc(1);
      test_core_tick();
      test_periodic();
      test_free();
      test_oneshot();
      test_prescale(12, TWS_DIV_16, 16);
      test_prescale(13, TWS_DIV_256, 256);
      test_slow_unit();
      test_supervision();
      conclude();
   end

   // Watchdog against a hang
   initial begin
      #200000;
      fail_count++;
      conclude();
   end
endmodule
